/* File: verilog/flash_ctl_pkg.sv */
/*
 Constants, command carrier and sequencer states for the flash write control front end.
 Assumes a 16-bit peripheral bus with byte addresses and two byte enables.
*/
package flash_ctl_pkg;
	// Register map
	localparam logic [23:0] LOW_ADDR = 24'h0E0000;
	localparam logic [23:0] HIGH_ADDR = 24'h0E0002;
	localparam logic [23:0] REG_LAST = 24'h0E0015;
	localparam logic [15:0] RESET_VAL = 16'h0000;
	localparam logic [15:0] TRAP_CODE = 16'h009B;
	// Low word fields
	localparam int L_BANK1 = 6;
	localparam int L_BANK0 = 5;
	localparam int L_LOCK = 4;
	localparam int L_BANK3 = 2;
	localparam int L_BANK2 = 1;
	// High word fields
	localparam int H_START = 15;
	localparam int H_OPERATION_SUSPEND = 14;
	localparam int H_WPG = 13;
	localparam int H_DOUBLE_WORD_PROGRAM_SELECT = 12;
	localparam int H_SER = 11;
	localparam int H_SPR = 8;
	localparam int H_MODULE_SELECT = 7;
	localparam logic [15:0] HIGH_WMASK = 16'hF980;
	// Protection registers live in bank 2
	localparam logic [1:0] PROT_BANK = 2'h2;

	typedef struct packed {
		logic start;
		logic resume;
		logic word;
		logic dword;
		logic erase;
		logic protect;
		logic module_sel;
		logic [1:0] bank;
	} op_cmd_t;

	typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_OPERATION_SUSPEND} seq_state_t;
endpackage

/* File: verilog/bank_access_guard.sv */
/*
 Gate for CPU accesses to the flash arrays: blocks busy banks and the test sector.
 Assumes bootstrap is already synchronised and bank_busy comes from the same clock.
*/
module bank_access_guard (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// State from the control block
	input wire logic [3:0] bank_busy,
	input wire logic bootstrap,
	// Array access
	input wire logic arr_req,
	input wire logic arr_we,
	input wire logic [1:0] arr_bank,
	input wire logic arr_test_sector,
	output logic arr_grant,
	output logic arr_trap
);
	wire bank_blocked = bank_busy[arr_bank];
	// Writes never reach the test sector; reads only in bootstrap mode
	wire test_hidden = arr_test_sector & (arr_we | ~bootstrap); // R12 R13
	assign arr_grant = arr_req & ~bank_blocked & ~test_hidden; // R4

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			arr_trap <= 1'b0;
		end else begin
			arr_trap <= arr_req & ~arr_we & bank_blocked; // R3
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	chk_busy_read_trap: assert property ( // R3
		(arr_req && !arr_we && bank_busy[arr_bank]) |=> arr_trap)
		else $error("read of busy bank did not trap");
	chk_busy_write_drop: assert property ( // R4
		(arr_req && arr_we && bank_busy[arr_bank]) |-> !arr_grant)
		else $error("write to busy bank was granted");
	chk_test_write_deny: assert property ( // R12
		(arr_req && arr_we && arr_test_sector) |-> !arr_grant)
		else $error("write to test sector was granted");
	chk_test_hidden: assert property ( // R13
		(arr_req && arr_test_sector && !bootstrap) |-> !arr_grant)
		else $error("test sector visible outside bootstrap");
endmodule

/* File: verilog/flash_write_control_status.sv */
/*
 Control low/high words of the flash program/erase controller, with launch, suspend,
 resume and completion sequencing and the bank access guard.
 Assumes the program/erase engine and the data, address and error registers sit outside
 and share core_clk; the bootstrap strap arrives asynchronously on a pin.
*/
// Summary of operation
// R1: Start of a write on the 16-bit module marks the target bank 3 or 2 busy.
// R2: A set-protection operation always marks bank 2 busy.
// R3: Reading a busy bank gives invalid data and raises trap 009Bh.
// R4: Writing a busy bank is ignored.
// R5: Busy clears at end of operation or when a suspend takes effect.
// R6: Resuming a suspended operation sets the affected busy flags again.
// R7: Banks 1 and 0 of the 32-bit module behave the same way.
// R8: While locked, control registers read invalid with trap and ignore writes.
// R9: Setting write start sets the lock flag at once.
// R10: The lock flag stays readable; software polls it before other accesses.
// R11: Error register updates only once lock and all busy flags are clear.
// R12: User writes to the test sector are always denied.
// R13: The test sector is visible only in bootstrap mode.
// R14: Both control words reset to zero.
// R15: Software loads address, data and operation before setting write start.
// R16: Module select picks 16-bit or 32-bit module and clears at the end.
// R17: Only one program or erase runs at a time.
// R18: Low word holds busy 1,0 at 6,5, lock at 4, busy 3,2 at 2,1.
// R19: High word holds start, suspend, word, double word, erase at bits 15 to 11.
module flash_write_control_status (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// Peripheral register bus
	input wire logic [23:0] bus_addr,
	input wire logic [15:0] bus_wdata,
	input wire logic [1:0] bus_be,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [15:0] bus_rdata,
	output logic bus_trap,
	output logic [15:0] trap_code,
	// Program/erase engine
	input wire logic [1:0] target_bank,
	input wire logic engine_suspended,
	input wire logic op_done,
	output flash_ctl_pkg::op_cmd_t cmd,
	output logic suspend_req,
	output logic reg_lock,
	output logic [3:0] bank_busy,
	output logic err_update_en,
	// Array access
	input wire logic bootstrap_pin,
	input wire logic arr_req,
	input wire logic arr_we,
	input wire logic [1:0] arr_bank,
	input wire logic arr_test_sector,
	output logic arr_grant,
	output logic arr_trap
);
	function automatic logic [3:0] bank_mask(input logic [1:0] b);
		bank_mask = 4'h1 << b;
	endfunction

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
		input logic [1:0] be);
		merge = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
	endfunction

	logic [15:0] high_word;
	logic lock;
	logic [3:0] busy;
	logic [1:0] op_bank;
	logic boot_meta;
	logic boot_sync;
	flash_ctl_pkg::seq_state_t state;
	flash_ctl_pkg::seq_state_t next_state;
	flash_ctl_pkg::op_cmd_t next_cmd;

	// Address decode
	wire [23:0] word_addr = {bus_addr[23:1], 1'b0};
	wire hit_low = word_addr == flash_ctl_pkg::LOW_ADDR;
	wire hit_high = word_addr == flash_ctl_pkg::HIGH_ADDR;
	wire in_range = (bus_addr >= flash_ctl_pkg::LOW_ADDR) && (bus_addr <= flash_ctl_pkg::REG_LAST);

	// Write qualification
	wire [15:0] wr_value = merge(high_word, bus_wdata, bus_be) & flash_ctl_pkg::HIGH_WMASK; // R19
	wire wr_high_ok = bus_wr & hit_high & ~lock; // R8
	wire go_bit = wr_value[flash_ctl_pkg::H_START] & ~wr_value[flash_ctl_pkg::H_OPERATION_SUSPEND];
	wire start_ok = wr_high_ok & go_bit & (state == flash_ctl_pkg::ST_IDLE); // R17
	wire resume_ok = wr_high_ok & go_bit & (state == flash_ctl_pkg::ST_OPERATION_SUSPEND);
	// Suspend must reach the engine while locked; it is passed on, not stored
	wire operation_suspend_hit = bus_wr & hit_high & bus_be[1] & bus_wdata[flash_ctl_pkg::H_OPERATION_SUSPEND]
		& (state == flash_ctl_pkg::ST_RUN);
	// Clear module select means 16-bit module banks 3/2, set means banks 1/0
	wire [1:0] launch_bank = wr_value[flash_ctl_pkg::H_SPR] ? flash_ctl_pkg::PROT_BANK : // R2
		{~wr_value[flash_ctl_pkg::H_MODULE_SELECT], target_bank[0]}; // R16 R7
	wire run_done = (state == flash_ctl_pkg::ST_RUN) & op_done;
	wire run_operation_suspend = (state == flash_ctl_pkg::ST_RUN) & engine_suspended & ~op_done;

	// Read path
	wire [15:0] low_full = {9'h000, busy[1], busy[0], lock, 1'b0, busy[3], busy[2], 1'b0}; // R18
	wire [15:0] low_view = lock ? (16'h0001 << flash_ctl_pkg::L_LOCK) : low_full; // R10
	wire rd_blocked = bus_rd & in_range & ~hit_low & lock; // R8
	wire [15:0] rd_value = hit_low ? low_view : (hit_high ? high_word : 16'h0000);

	assign next_cmd.start = start_ok;
	assign next_cmd.resume = resume_ok;
	assign next_cmd.word = wr_value[flash_ctl_pkg::H_WPG];
	assign next_cmd.dword = wr_value[flash_ctl_pkg::H_DOUBLE_WORD_PROGRAM_SELECT];
	assign next_cmd.erase = wr_value[flash_ctl_pkg::H_SER];
	assign next_cmd.protect = wr_value[flash_ctl_pkg::H_SPR];
	assign next_cmd.module_sel = wr_value[flash_ctl_pkg::H_MODULE_SELECT];
	assign next_cmd.bank = start_ok ? launch_bank : op_bank;

	always_comb begin
		next_state = state;
		case (state)
			flash_ctl_pkg::ST_IDLE: begin
				if (start_ok) begin
					next_state = flash_ctl_pkg::ST_RUN;
				end
			end
			flash_ctl_pkg::ST_RUN: begin
				if (run_done) begin
					next_state = flash_ctl_pkg::ST_IDLE;
				end else if (run_operation_suspend) begin
					next_state = flash_ctl_pkg::ST_OPERATION_SUSPEND;
				end
			end
			flash_ctl_pkg::ST_OPERATION_SUSPEND: begin
				if (resume_ok) begin
					next_state = flash_ctl_pkg::ST_RUN;
				end
			end
			default: next_state = flash_ctl_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state <= flash_ctl_pkg::ST_IDLE;
			high_word <= flash_ctl_pkg::RESET_VAL; // R14
			lock <= 1'b0; // R14
			busy <= 4'h0; // R14
			op_bank <= 2'h0;
		end else begin
			state <= next_state;
			if (run_done) begin
				high_word <= flash_ctl_pkg::RESET_VAL; // R16
			end else if (wr_high_ok) begin
				high_word <= wr_value;
			end
			if (start_ok | resume_ok) begin
				lock <= 1'b1; // R9
			end else if (run_done | run_operation_suspend) begin
				lock <= 1'b0;
			end
			if (start_ok) begin
				busy <= bank_mask(launch_bank); // R1 R7
				op_bank <= launch_bank;
			end else if (resume_ok) begin
				busy <= bank_mask(op_bank); // R6
			end else if (run_done | run_operation_suspend) begin
				busy <= 4'h0; // R5
			end
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cmd <= '0;
			suspend_req <= 1'b0;
			bus_rdata <= 16'h0000;
			bus_trap <= 1'b0;
			boot_meta <= 1'b0;
			boot_sync <= 1'b0;
		end else begin
			if (start_ok | resume_ok) begin
				cmd <= next_cmd;
			end else begin
				cmd.start <= 1'b0;
				cmd.resume <= 1'b0;
			end
			suspend_req <= operation_suspend_hit;
			bus_rdata <= rd_blocked ? 16'h0000 : rd_value; // R8
			bus_trap <= rd_blocked; // R8
			boot_meta <= bootstrap_pin;
			boot_sync <= boot_meta;
		end
	end

	assign trap_code = flash_ctl_pkg::TRAP_CODE;
	assign reg_lock = lock;
	assign bank_busy = busy;
	assign err_update_en = ~lock & ~|busy; // R11

	bank_access_guard u_guard (
		.core_clk(core_clk),
		.rstn(rstn),
		.bank_busy(busy),
		.bootstrap(boot_sync),
		.arr_req(arr_req),
		.arr_we(arr_we),
		.arr_bank(arr_bank),
		.arr_test_sector(arr_test_sector),
		.arr_grant(arr_grant),
		.arr_trap(arr_trap)
	);

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	sequence seq_launch;
		start_ok && !wr_value[flash_ctl_pkg::H_SPR];
	endsequence
	sequence seq_engaged;
		lock && (busy == bank_mask($past(launch_bank)));
	endsequence

	chk_launch_busy: assert property (seq_launch |=> seq_engaged) // R1
		else $error("launch did not mark target bank busy");
	chk_protect_bank: assert property ( // R2
		(start_ok && wr_value[flash_ctl_pkg::H_SPR]) |=> (busy == 4'h4))
		else $error("set protection did not mark bank 2");
	chk_start_lock: assert property ( // R9
		start_ok |=> reg_lock ##0 (state == flash_ctl_pkg::ST_RUN) ##0 cmd.start)
		else $error("lock not set after start");
	chk_done_clears: assert property ( // R5 R16
		run_done |=> (busy == 4'h0 && !lock && !high_word[flash_ctl_pkg::H_MODULE_SELECT]))
		else $error("completion did not clear flags");
	chk_operation_suspend_clears: assert property ( // R5
		run_operation_suspend |=> (busy == 4'h0 && state == flash_ctl_pkg::ST_OPERATION_SUSPEND))
		else $error("suspend did not clear busy");
	chk_resume_busy: assert property ( // R6
		resume_ok |=> (busy == bank_mask(op_bank) && lock && cmd.resume))
		else $error("resume did not restore busy");
	chk_locked_read: assert property ( // R8
		(bus_rd && hit_high && lock) |=> (bus_trap && bus_rdata == 16'h0000))
		else $error("locked read did not trap");
	chk_locked_write: assert property ( // R8
		(bus_wr && hit_high && lock && !run_done) |=> $stable(high_word))
		else $error("locked write changed control word");
	chk_single_op: assert property ( // R17
		(bus_wr && hit_high && bus_wdata[flash_ctl_pkg::H_START] && state != flash_ctl_pkg::ST_IDLE
			&& state != flash_ctl_pkg::ST_OPERATION_SUSPEND) |=> !cmd.start)
		else $error("second operation launched");
	// Lock and busy clear together, so the enable may only rise after completion or suspend
	chk_err_window: assert property ( // R11
		$rose(err_update_en) |-> ($past(run_done) || $past(run_operation_suspend)))
		else $error("error update enabled without completion or suspend");
endmodule

/* File: dv/testbench.sv */
/*
 Self-checking bench for the flash write control front end: register words, launch,
 suspend/resume, completion and array gating.
 Assumes the design package is compiled first; the bench plays CPU and engine itself.
*/
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic [23:0] bus_addr = 24'h000000;
	logic [15:0] bus_wdata = 16'h0000;
	logic [1:0] bus_be = 2'h3;
	logic bus_wr = 1'b0;
	logic bus_rd = 1'b0;
	logic [15:0] bus_rdata;
	logic bus_trap;
	logic [15:0] trap_code;
	logic [1:0] target_bank = 2'h0;
	logic engine_suspended = 1'b0;
	logic op_done = 1'b0;
	flash_ctl_pkg::op_cmd_t cmd;
	logic suspend_req;
	logic reg_lock;
	logic [3:0] bank_busy;
	logic err_update_en;
	logic bootstrap_pin = 1'b0;
	logic arr_req = 1'b0;
	logic arr_we = 1'b0;
	logic [1:0] arr_bank = 2'h0;
	logic arr_test_sector = 1'b0;
	logic arr_grant;
	logic arr_trap;
	int bad_count = 0;
	int comparisons = 0;
	localparam logic [23:0] LO = flash_ctl_pkg::LOW_ADDR;
	localparam logic [23:0] HI = flash_ctl_pkg::HIGH_ADDR;

	flash_write_control_status flash_write_control_status_i (.core_clk(core_clk), .rstn(rstn),
		.bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_be(bus_be), .bus_wr(bus_wr),
		.bus_rd(bus_rd), .bus_rdata(bus_rdata), .bus_trap(bus_trap), .trap_code(trap_code),
		.target_bank(target_bank), .engine_suspended(engine_suspended), .op_done(op_done),
		.cmd(cmd), .suspend_req(suspend_req), .reg_lock(reg_lock), .bank_busy(bank_busy),
		.err_update_en(err_update_en), .bootstrap_pin(bootstrap_pin), .arr_req(arr_req),
		.arr_we(arr_we), .arr_bank(arr_bank), .arr_test_sector(arr_test_sector),
		.arr_grant(arr_grant), .arr_trap(arr_trap));

	always #4 core_clk = ~core_clk;

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic conclude;
		$display("mismatches %0d comparisons %0d", bad_count, comparisons);
		if (bad_count == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Returns one ns after the edge that took the write, so flag updates have landed
	task automatic wr(input logic [23:0] a, input logic [15:0] d, input logic [1:0] be);
		@(posedge core_clk);
		bus_addr <= a;
		bus_wdata <= d;
		bus_be <= be;
		bus_wr <= 1'b1;
		@(posedge core_clk);
		bus_wr <= 1'b0;
		#1;
	endtask

	task automatic rchk(input logic [23:0] a, input logic [15:0] exp_d, input logic exp_t);
		@(posedge core_clk);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge core_clk);
		bus_rd <= 1'b0;
		#1;
		check(bus_rdata, exp_d);
		check({15'h0, bus_trap}, {15'h0, exp_t});
	endtask

	task automatic acc(input logic [1:0] b, input logic we, input logic ts, input logic g,
			input logic t);
		@(posedge core_clk);
		arr_req <= 1'b1;
		arr_we <= we;
		arr_bank <= b;
		arr_test_sector <= ts;
		#1;
		check({15'h0, arr_grant}, {15'h0, g});
		@(posedge core_clk);
		arr_req <= 1'b0;
		#1;
		check({15'h0, arr_trap}, {15'h0, t});
	endtask

	task automatic finish_op;
		@(posedge core_clk);
		op_done <= 1'b1;
		@(posedge core_clk);
		op_done <= 1'b0;
		#1;
		check({11'h0, reg_lock, bank_busy}, 16'h0000);
	endtask

	task automatic t_regs;
		rchk(LO, 16'h0000, 1'b0);
		rchk(HI, 16'h0000, 1'b0);
		check(trap_code, flash_ctl_pkg::TRAP_CODE);
		wr(LO, 16'hFFFF, 2'h3);
		rchk(LO, 16'h0000, 1'b0);
		wr(HI, 16'h3E7F, 2'h3);
		rchk(HI, 16'h3800, 1'b0);
		wr(HI + 24'h1, 16'h0100, 2'h2);
		rchk(HI, 16'h0100, 1'b0);
		rchk(24'h0E0100, 16'h0000, 1'b0);
	endtask

	task automatic t_launch;
		@(posedge core_clk);
		target_bank <= 2'h0;
		wr(HI, 16'hA000, 2'h3);
		check({12'h0, bank_busy}, 16'h0004);
		check({15'h0, reg_lock}, 16'h0001);
		check({14'h0, cmd.start, cmd.word}, 16'h0003);
		check({7'h0, cmd}, 16'h0142);
		check({15'h0, err_update_en}, 16'h0000);
		rchk(LO, 16'h0010, 1'b0);
		rchk(HI, 16'h0000, 1'b1);
		rchk(24'h0E0014, 16'h0000, 1'b1);
		acc(2'h2, 1'b0, 1'b0, 1'b0, 1'b1);
		acc(2'h2, 1'b1, 1'b0, 1'b0, 1'b0);
		acc(2'h3, 1'b0, 1'b0, 1'b1, 1'b0);
		@(posedge core_clk);
		target_bank <= 2'h1;
		wr(HI, 16'h8080, 2'h3);
		check({12'h0, bank_busy}, 16'h0004);
		finish_op();
		check({15'h0, err_update_en}, 16'h0001);
		rchk(HI, 16'h0000, 1'b0);
	endtask

	task automatic t_suspend;
		@(posedge core_clk);
		target_bank <= 2'h1;
		wr(HI, 16'h8080, 2'h3);
		check({12'h0, bank_busy}, 16'h0002);
		check({15'h0, cmd.module_sel}, 16'h0001);
		check({7'h0, cmd}, 16'h0105);
		wr(HI, 16'h4000, 2'h3);
		check({15'h0, suspend_req}, 16'h0001);
		@(posedge core_clk);
		engine_suspended <= 1'b1;
		@(posedge core_clk);
		engine_suspended <= 1'b0;
		#1;
		check({11'h0, reg_lock, bank_busy}, 16'h0000);
		rchk(LO, 16'h0000, 1'b0);
		acc(2'h1, 1'b0, 1'b0, 1'b1, 1'b0);
		wr(HI, 16'h8080, 2'h3);
		check({11'h0, reg_lock, bank_busy}, 16'h0012);
		check({15'h0, cmd.resume}, 16'h0001);
		acc(2'h1, 1'b0, 1'b0, 1'b0, 1'b1);
		finish_op();
		rchk(HI, 16'h0000, 1'b0);
	endtask

	// Also erase on bank 3, double word on bank 0, then a reset while an operation runs
	task automatic t_protect;
		@(posedge core_clk);
		target_bank <= 2'h1;
		wr(HI, 16'h8100, 2'h3);
		check({12'h0, bank_busy}, 16'h0004);
		check({7'h0, cmd}, 16'h010A);
		finish_op();
		wr(HI, 16'h8800, 2'h3);
		check({12'h0, bank_busy}, 16'h0008);
		check({7'h0, cmd}, 16'h0113);
		finish_op();
		@(posedge core_clk);
		target_bank <= 2'h0;
		wr(HI, 16'h9080, 2'h3);
		check({12'h0, bank_busy}, 16'h0001);
		check({7'h0, cmd}, 16'h0124);
		acc(2'h0, 1'b0, 1'b0, 1'b0, 1'b1);
		@(posedge core_clk);
		rstn <= 1'b0;
		repeat (2) @(posedge core_clk);
		rstn <= 1'b1;
		#1;
		check({11'h0, reg_lock, bank_busy}, 16'h0000);
		rchk(HI, 16'h0000, 1'b0);
	endtask

	task automatic t_test_sector;
		acc(2'h0, 1'b0, 1'b1, 1'b0, 1'b0);
		acc(2'h0, 1'b1, 1'b1, 1'b0, 1'b0);
		@(posedge core_clk);
		bootstrap_pin <= 1'b1;
		repeat (3) @(posedge core_clk);
		acc(2'h0, 1'b0, 1'b1, 1'b1, 1'b0);
		acc(2'h0, 1'b1, 1'b1, 1'b0, 1'b0);
	endtask

	// Whole sequence takes under a hundred cycles; this leaves ample margin
	initial begin
		#200000;
		bad_count++;
		conclude();
	end

	initial begin
		repeat (2) @(posedge core_clk);
		rstn <= 1'b1;
		t_regs();
		t_launch();
		t_suspend();
		t_protect();
		t_test_sector();
		conclude();
	end
endmodule
